/* File: omc_array_asserts.sv */
// bus handshake and pin settling checks for the macrocell array
`timescale 1ns/1ps
module omc_array_asserts (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    // register bus
    input wire omc_pkg::omc_axi_req_s axi_req,
    input wire omc_pkg::omc_axi_rsp_s axi_rsp,
    // pins
    input wire logic                  pld_clk_pin,
    input wire logic [7:0]            data_in,
    input wire logic [9:0]            cell_pin_i,
    input wire logic [9:0]            cell_pin_o,
    input wire logic [9:0]            cell_pin_oe
);
    import omc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // cycles since any input last moved; outputs must have settled well before 8
    logic [3:0] quiet_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) quiet_q <= 4'h0;
        else if ($changed({axi_req, data_in, cell_pin_i, pld_clk_pin})) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end

    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    a_wr_latency: assert property (s_wr_take |=> axi_rsp.bvalid && !axi_rsp.awready)
        else $error("write answer not on next edge");
    a_rd_latency: assert property (s_rd_take |=> !axi_rsp.arready && axi_rsp.rvalid)
        else $error("read answer not on next edge");
    a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped early");
    a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped early");
    a_wr_busy: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write accepted while answer pending");
    a_rd_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read accepted while answer pending");
    a_b_release: assert property (axi_rsp.bvalid && axi_req.bready |=>
        !axi_rsp.bvalid && axi_rsp.awready)
        else $error("write channel not freed");
    a_r_release: assert property (axi_rsp.rvalid && axi_req.rready |=>
        !axi_rsp.rvalid && axi_rsp.arready)
        else $error("read channel not freed");
    a_pins_quiet: assert property (quiet_q >= 4'h8 |->
        $stable(cell_pin_o) && $stable(cell_pin_oe))
        else $error("pins moved with quiet inputs");
endmodule : omc_array_asserts

bind omc_macrocell_array omc_array_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pld_clk_pin(pld_clk_pin), .data_in(data_in),
    .cell_pin_i(cell_pin_i), .cell_pin_o(cell_pin_o), .cell_pin_oe(cell_pin_oe));

/* File: omc_board.sv */
// board model: pull-ups, input drivers and device clock pulses
`timescale 1ns/1ps
module omc_board (
    // clock
    input  wire logic       core_clk,
    // device side
    input  wire logic [9:0] pin_o,
    input  wire logic [9:0] pin_oe,
    // board side
    output logic            pld_clk,
    output logic [7:0]      din,
    output logic [9:0]      pin_i
);
    logic [9:0] ext_en;
    logic [9:0] ext_val;
    initial begin
        pld_clk = 1'b0;
        din = 8'h00;
        ext_en = 10'h000;
        ext_val = 10'h000;
    end
    // released pins without a board driver float high through the pull-ups
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);

    // high phase of n core cycles, low phase of n+2; below 2 the device would not see them
    task automatic pulse(input int n);
        @(posedge core_clk);
        pld_clk <= 1'b1;
        repeat (n) @(posedge core_clk);
        pld_clk <= 1'b0;
        repeat (n + 2) @(posedge core_clk);
    endtask : pulse
    task automatic set_in(input logic [7:0] v);
        @(posedge core_clk);
        din <= v;
        repeat (6) @(posedge core_clk);
    endtask : set_in
    task automatic drive(input logic [9:0] en, input logic [9:0] v);
        @(posedge core_clk);
        ext_en <= en;
        ext_val <= v;
    endtask : drive
endmodule : omc_board

/* File: omc_macrocell_array.sv */
// output macrocell array with shared and-array, configuration over axi4-lite
//
// How it works
// - ten cells; two sum ten product terms, eight sum eight terms
// - each cell has one extra product term driving its output enable
// - each cell selects true or inverted output polarity in both modes
// - one shared clear term forces all cell registers to zero at once
// - one shared set term loads one into all registers at next clock
// - clear and set act on flip-flop state; pin level follows polarity
// - two per-cell select bits choose mode and output polarity
// - registered cell drives its pin from the flip-flop sampling its sum
// - registered cell feeds the complemented flip-flop output back, both forms
// - registered cell pin is output only, its level never returns to array
// - combinatorial cell drives its pin from the sum term directly
// - combinatorial enable is always on, always off, or product term
// - combinatorial feedback comes from the pin level, both forms
// - registers clear on reset and can be preloaded for testing
// - a readable signature is held beside the configuration
// - signature is eight bytes, byte zero to byte seven
`timescale 1ns/1ps
module omc_macrocell_array #(
    parameter logic [63:0] SIG_RESET = 64'h0000000000000000
) (
    // clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             sys_rst,
    // register bus
    input  wire omc_pkg::omc_axi_req_s             axi_req,
    output omc_pkg::omc_axi_rsp_s                  axi_rsp,
    // device pins
    input  wire logic                             pld_clk_pin,
    input  wire logic [omc_pkg::NUM_INPUTS-1:0]    data_in,
    input  wire logic [omc_pkg::NUM_CELLS-1:0]     cell_pin_i,
    output logic      [omc_pkg::NUM_CELLS-1:0]     cell_pin_o,
    output logic      [omc_pkg::NUM_CELLS-1:0]     cell_pin_oe
);
    import omc_pkg::*;

    typedef struct packed {
        omc_axi_rsp_s                rsp;
        logic                        aw_have;
        logic [ADDR_W-1:0]           aw_addr;
        logic                        w_have;
        logic [DATA_W-1:0]           w_data;
        logic [STRB_W-1:0]           w_strb;
        logic [NUM_CELLS-1:0]        polarity;
        logic [NUM_CELLS-1:0]        mode;
        logic [2*NUM_CELLS-1:0]      oe_sel;
        logic [SIG_W-1:0]            sig;
        omc_term_s [NUM_TERMS-1:0]   terms;
        logic                        preload_stb;
        logic [NUM_CELLS-1:0]        preload_val;
        logic [EXT_W-1:0]            s1;
        logic [EXT_W-1:0]            s2;
        logic [EXT_W-1:0]            s3;
        logic [EXT_W-1:0]            filt;
        logic                        clk_prev;
    } omc_top_state_s;

    omc_top_state_s st_q;
    omc_top_state_s st_d;

    logic [NUM_CELLS-1:0] cell_q;
    logic [NUM_CELLS-1:0] feedback;
    logic [ARRAY_W-1:0]   array_in;
    logic [NUM_TERMS-1:0] hit;
    logic [NUM_CELLS-1:0] sum;
    logic                 tick;
    logic [EXT_W-1:0]     agree;

    // byte-lane merge for partial writes
    function automatic logic [DATA_W-1:0] omc_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : omc_merge

    function automatic logic omc_is_term(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - REG_TERM_BASE;
        return (a >= REG_TERM_BASE) && (a[1:0] == 2'h0)
            && ((off >> TERM_SHIFT) < ADDR_W'(NUM_TERMS));
    endfunction : omc_is_term

    function automatic logic [ADDR_W-1:0] omc_term_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - REG_TERM_BASE;
        return off >> TERM_SHIFT;
    endfunction : omc_term_idx

    // pin inputs: a level change counts once the second and third stages agree
    assign agree    = ~(st_q.s2 ^ st_q.s3);
    assign tick     = st_q.filt[CLK_BIT] & ~st_q.clk_prev;

    // feedback source depends on mode
    always_comb begin
        for (int c = 0; c < NUM_CELLS; c++) begin
            if (st_q.mode[c]) begin
                feedback[c] = st_q.filt[NUM_INPUTS + c];
            end else begin
                feedback[c] = ~cell_q[c];
            end
        end
    end
    assign array_in = {feedback, st_q.filt[NUM_INPUTS-1:0]};

    // a term with a column connected to both forms is always false
    genvar gt;
    generate
        for (gt = 0; gt < NUM_TERMS; gt++) begin : g_term
            assign hit[gt] = &((~st_q.terms[gt].true_mask | array_in)
                             & (~st_q.terms[gt].comp_mask | ~array_in));
        end
    endgenerate

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CELLS; gc++) begin : g_cell
            localparam int CNT = WIDE_CELLS[gc] ? TERMS_WIDE : TERMS_NARROW;
            omc_cell_cfg_s cfg;
            assign sum[gc] = |hit[gc*SLOT_W +: CNT];
            assign cfg.polarity_true = st_q.polarity[gc];
            assign cfg.comb_mode     = st_q.mode[gc];
            assign cfg.oe_sel        = omc_oe_sel_e'(st_q.oe_sel[2*gc +: 2]);
            omc_output_macrocell u_cell (
                .core_clk    (core_clk),
                .sys_rst     (sys_rst),
                .cfg         (cfg),
                .sum_term    (sum[gc]),
                .oe_term     (hit[gc*SLOT_W + OE_SLOT]),
                .tick        (tick),
                .clear       (hit[CLEAR_TERM]),
                .set         (hit[SET_TERM]),
                .preload_stb (st_q.preload_stb),
                .preload_val (st_q.preload_val[gc]),
                .q           (cell_q[gc]),
                .pin_o       (cell_pin_o[gc]),
                .pin_oe      (cell_pin_oe[gc])
            );
        end
    endgenerate

    always_comb begin
        logic [ADDR_W-1:0] idx;
        logic [DATA_W-1:0] old_w;
        logic [DATA_W-1:0] new_w;
        idx   = '0;
        old_w = '0;
        new_w = '0;
        st_d  = st_q;
        st_d.preload_stb = 1'b0;

        st_d.s1       = {pld_clk_pin, cell_pin_i, data_in};
        st_d.s2       = st_q.s1;
        st_d.s3       = st_q.s2;
        st_d.filt     = (st_q.filt & ~agree) | (st_q.s3 & agree);
        st_d.clk_prev = st_q.filt[CLK_BIT];

        // write channel: address and data are taken in either order
        if (st_q.rsp.bvalid && axi_req.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        if (axi_req.awvalid && st_q.rsp.awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_q.rsp.wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = axi_req.wdata;
            st_d.w_strb = axi_req.wstrb;
        end
        if (st_d.aw_have && st_d.w_have && !st_d.rsp.bvalid) begin
            st_d.aw_have    = 1'b0;
            st_d.w_have     = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp  = RESP_OKAY;
            case (st_d.aw_addr)
                REG_POLARITY: begin
                    new_w = omc_merge(DATA_W'(st_q.polarity), st_d.w_data, st_d.w_strb);
                    st_d.polarity = new_w[NUM_CELLS-1:0];
                end
                REG_MODE: begin
                    new_w = omc_merge(DATA_W'(st_q.mode), st_d.w_data, st_d.w_strb);
                    st_d.mode = new_w[NUM_CELLS-1:0];
                end
                REG_OE_SEL: begin
                    new_w = omc_merge(DATA_W'(st_q.oe_sel), st_d.w_data, st_d.w_strb);
                    st_d.oe_sel = new_w[2*NUM_CELLS-1:0];
                end
                REG_PRELOAD: begin
                    new_w = omc_merge('0, st_d.w_data, st_d.w_strb);
                    st_d.preload_stb = 1'b1;
                    st_d.preload_val = new_w[NUM_CELLS-1:0];
                end
                REG_SIG_LO: begin
                    new_w = omc_merge(st_q.sig[DATA_W-1:0], st_d.w_data, st_d.w_strb);
                    st_d.sig[DATA_W-1:0] = new_w;
                end
                REG_SIG_HI: begin
                    new_w = omc_merge(st_q.sig[SIG_W-1:DATA_W], st_d.w_data, st_d.w_strb);
                    st_d.sig[SIG_W-1:DATA_W] = new_w;
                end
                REG_CELL_Q, REG_PIN_IN, REG_INPUT_IN: begin
                    st_d.rsp.bresp = RESP_OKAY;
                end
                default: begin
                    if (omc_is_term(st_d.aw_addr)) begin
                        idx = omc_term_idx(st_d.aw_addr);
                        if (st_d.aw_addr[TERM_HALF_BIT]) begin
                            old_w = DATA_W'(st_q.terms[idx].comp_mask);
                            new_w = omc_merge(old_w, st_d.w_data, st_d.w_strb);
                            st_d.terms[idx].comp_mask = new_w[ARRAY_W-1:0];
                        end else begin
                            old_w = DATA_W'(st_q.terms[idx].true_mask);
                            new_w = omc_merge(old_w, st_d.w_data, st_d.w_strb);
                            st_d.terms[idx].true_mask = new_w[ARRAY_W-1:0];
                        end
                    end else begin
                        st_d.rsp.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        st_d.rsp.awready = !st_d.aw_have && !st_d.rsp.bvalid;
        st_d.rsp.wready  = !st_d.w_have && !st_d.rsp.bvalid;

        // read channel: one read in flight, answer one cycle after acceptance
        if (st_q.rsp.rvalid && axi_req.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_q.rsp.arready) begin
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rresp  = RESP_OKAY;
            st_d.rsp.rdata  = '0;
            case (axi_req.araddr)
                REG_POLARITY: st_d.rsp.rdata = DATA_W'(st_q.polarity);
                REG_MODE:     st_d.rsp.rdata = DATA_W'(st_q.mode);
                REG_OE_SEL:   st_d.rsp.rdata = DATA_W'(st_q.oe_sel);
                REG_PRELOAD:  st_d.rsp.rdata = '0;
                REG_CELL_Q:   st_d.rsp.rdata = DATA_W'(cell_q);
                REG_PIN_IN:   st_d.rsp.rdata = DATA_W'(st_q.filt[NUM_INPUTS +: NUM_CELLS]);
                REG_INPUT_IN: st_d.rsp.rdata = DATA_W'(st_q.filt[NUM_INPUTS-1:0]);
                REG_SIG_LO:   st_d.rsp.rdata = st_q.sig[DATA_W-1:0];
                REG_SIG_HI:   st_d.rsp.rdata = st_q.sig[SIG_W-1:DATA_W];
                default: begin
                    if (omc_is_term(axi_req.araddr)) begin
                        idx = omc_term_idx(axi_req.araddr);
                        if (axi_req.araddr[TERM_HALF_BIT]) begin
                            st_d.rsp.rdata = DATA_W'(st_q.terms[idx].comp_mask);
                        end else begin
                            st_d.rsp.rdata = DATA_W'(st_q.terms[idx].true_mask);
                        end
                    end else begin
                        st_d.rsp.rresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        st_d.rsp.arready = !st_d.rsp.rvalid;
    end

    // configuration and signature survive only until the next reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q             <= '0;
            st_q.rsp.awready <= 1'b1;
            st_q.rsp.wready  <= 1'b1;
            st_q.rsp.arready <= 1'b1;
            st_q.polarity    <= POLARITY_RST;
            st_q.mode        <= MODE_RST;
            st_q.oe_sel      <= OE_SEL_RST;
            st_q.sig         <= SIG_RESET;
            // every term starts with both forms of each column connected, so it is false
            for (int t = 0; t < NUM_TERMS; t++) begin
                st_q.terms[t] <= {MASK_RST, MASK_RST};
            end
        end else begin
            st_q <= st_d;
        end
    end

    assign axi_rsp = st_q.rsp;

endmodule : omc_macrocell_array

/* File: omc_macrocell_array_tb.sv */
// self-checking bench for the macrocell array
`timescale 1ns/1ps
module omc_macrocell_array_tb;
    import omc_pkg::*;
    localparam logic [63:0] SIG = 64'h5a3c96e10f87d2b4; // arbitrary contents
    localparam logic [7:0]  IN1 [3] = '{8'h02, 8'h01, 8'h01};
    localparam logic [31:0] QX [3] = '{32'h012, 32'h003, 32'h001};
    localparam logic [1:0]  SEL [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    localparam logic [7:0]  DV [4] = '{8'h04, 8'h04, 8'h0c, 8'h00};
    localparam logic        OX [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic         core_clk;
    logic         sys_rst;
    omc_axi_req_s req;
    omc_axi_rsp_s rsp;
    logic         pclk;
    logic [7:0]   din;
    logic [9:0]   pin_i;
    logic [9:0]   pin_o;
    logic [9:0]   pin_oe;
    int           err_count;
    int           n_tests;
    bit           slow;
    logic [31:0]  d;
    logic [1:0]   r;

    omc_macrocell_array #(.SIG_RESET(SIG)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .axi_req(req), .axi_rsp(rsp), .pld_clk_pin(pclk), .data_in(din),
        .cell_pin_i(pin_i), .cell_pin_o(pin_o), .cell_pin_oe(pin_oe));
    omc_board board (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pld_clk(pclk),
        .din(din), .pin_i(pin_i));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // responses are read just after the edge, before the flops there update
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit aw;
        bit w;
        @(posedge core_clk);
        aw = 1;
        w = 1;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.bready <= !slow;
        forever begin
            @(posedge core_clk);
            if (aw && rsp.awready) begin
                aw = 0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 0;
                req.wvalid <= 1'b0;
            end
            if (rsp.bvalid && req.bready) begin
                chk("bresp", 32'(RESP_OKAY), 32'(rsp.bresp));
                req.bready <= 1'b0;
                break;
            end
            if (rsp.bvalid) req.bready <= 1'b1;
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
        @(posedge core_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= !slow;
        forever begin
            @(posedge core_clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                v = rsp.rdata;
                rr = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
            if (rsp.rvalid) req.rready <= 1'b1;
        end
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        rd(a, d, r);
        chk(nm, exp, d);
        chk("rresp", 32'(RESP_OKAY), 32'(r));
    endtask : rc
    task automatic tm(input int t, input logic [31:0] tv, input logic [31:0] cv);
        wr(REG_TERM_BASE + 12'(t * 8), tv);
        wr(REG_TERM_BASE + 12'(t * 8 + 4), cv);
    endtask : tm
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_sim();
    end

    initial begin
        req = '0;
        sys_rst = 1'b1;
        err_count = 0;
        n_tests = 0;
        slow = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rc(REG_POLARITY, 32'h3ff, "polarity");
        rc(REG_MODE, 32'h000, "mode");
        rc(REG_SIG_LO, SIG[31:0], "sig_lo");
        rc(REG_SIG_HI, SIG[63:32], "sig_hi");
        rc(REG_CELL_Q, 32'h000, "cell_q");
        chk("pin_oe", 32'h000, 32'(pin_oe));
        rd(12'h024, d, r);
        chk("unmapped", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0, d);
        slow = 1;
        wr(REG_SIG_HI, 32'hc3a57e11);
        rc(REG_SIG_HI, 32'hc3a57e11, "sig store");
        // cell 0 from input 0, its tenth term unused; wide cell 4 uses its tenth
        tm(0, 32'h1, 32'h0);
        tm(9, 32'h2, 32'h0);
        tm(53, 32'h2, 32'h0);
        tm(11, 32'h100, 32'h0);
        tm(10, 32'h0, 32'h0);
        for (int i = 0; i < 3; i++) begin
            board.set_in(IN1[i]);
            board.pulse(4 + 4 * i);
            rc(REG_CELL_Q, QX[i], "cell_q");
        end
        chk("pin_o", 32'h001, 32'(pin_o));
        chk("pin_oe", 32'h001, 32'(pin_oe));
        wr(REG_POLARITY, 32'h000);
        repeat (3) @(posedge core_clk);
        chk("pin_o inverted", 32'h3fe, 32'(pin_o));
        slow = 0;
        tm(111, 32'h0, 32'h0);
        board.pulse(4);
        rc(REG_CELL_Q, 32'h3ff, "set");
        chk("pin_o set", 32'h000, 32'(pin_o));
        tm(110, 32'h0, 32'h0);
        rc(REG_CELL_Q, 32'h000, "clear");
        board.pulse(4);
        rc(REG_CELL_Q, 32'h000, "clear over set");
        chk("pin_o clear", 32'h3ff, 32'(pin_o));
        tm(111, 32'h3ffff, 32'h3ffff);
        tm(110, 32'h3ffff, 32'h3ffff);
        wr(REG_POLARITY, 32'h3ff);
        wr(REG_PRELOAD, 32'h2a5);
        rc(REG_CELL_Q, 32'h2a5, "preload");
        // cell 2 combinatorial, enable term on input 3; cell 3 samples pin 2
        wr(REG_MODE, 32'h004);
        tm(22, 32'h4, 32'h0);
        tm(32, 32'h8, 32'h0);
        tm(33, 32'h400, 32'h0);
        board.drive(10'h004, 10'h000);
        for (int i = 0; i < 4; i++) begin
            wr(REG_OE_SEL, 32'(SEL[i]) << 4);
            board.set_in(DV[i]);
            board.pulse(4);
            chk("oe cell 2", 32'(OX[i]), 32'(pin_oe[2]));
            chk("pin cell 2", 32'(DV[i][2]), 32'(pin_o[2]));
            rd(REG_CELL_Q, d, r);
            chk("pin feedback", 32'(OX[i]), 32'(d[3]));
        end
        end_sim();
    end
endmodule : omc_macrocell_array_tb

/* File: omc_output_macrocell.sv */
// one output macrocell: register, polarity stage and output enable
`timescale 1ns/1ps
module omc_output_macrocell (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // configuration
    input  wire omc_pkg::omc_cell_cfg_s cfg,
    // array terms
    input  wire logic                  sum_term,
    input  wire logic                  oe_term,
    input  wire logic                  clear,
    input  wire logic                  set,
    // timing and test
    input  wire logic                  tick,
    input  wire logic                  preload_stb,
    input  wire logic                  preload_val,
    // cell outputs
    output logic                       q,
    output logic                       pin_o,
    output logic                       pin_oe
);
    import omc_pkg::*;

    typedef struct packed {
        logic q;
        logic pin_o;
        logic pin_oe;
    } omc_cell_state_s;

    omc_cell_state_s s_q;
    omc_cell_state_s s_d;

    always_comb begin
        s_d = s_q;
        // clear wins over preload and set, and holds while its term stays on
        if (clear) begin
            s_d.q = 1'b0;
        end else if (preload_stb) begin
            s_d.q = preload_val;
        end else if (tick) begin
            s_d.q = set | sum_term;
        end
        // polarity acts after the flip-flop, so with inverted polarity clear and set reach a registered pin inverted
        s_d.pin_o = cfg.comb_mode ? sum_term : s_d.q;
        s_d.pin_o = cfg.polarity_true ? s_d.pin_o : ~s_d.pin_o;
        if (!cfg.comb_mode) begin
            s_d.pin_oe = oe_term;
        end else begin
            case (cfg.oe_sel)
                OE_ALWAYS_ON:  s_d.pin_oe = 1'b1;
                OE_ALWAYS_OFF: s_d.pin_oe = 1'b0;
                default:       s_d.pin_oe = oe_term;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q      = s_q.q;
    assign pin_o  = s_q.pin_o;
    assign pin_oe = s_q.pin_oe;

endmodule : omc_output_macrocell

/* File: omc_pkg.sv */
// shared constants and types for the output macrocell array
package omc_pkg;

    // array geometry
    localparam int NUM_CELLS    = 10;
    localparam int NUM_INPUTS   = 8;
    localparam int ARRAY_W      = NUM_INPUTS + NUM_CELLS;
    localparam int SLOT_W       = 11;
    localparam int OE_SLOT      = 10;
    localparam int TERMS_WIDE   = 10;
    localparam int TERMS_NARROW = 8;
    localparam int NUM_TERMS    = NUM_CELLS * SLOT_W + 2;
    localparam int CLEAR_TERM   = NUM_CELLS * SLOT_W;
    localparam int SET_TERM     = NUM_CELLS * SLOT_W + 1;
    localparam int EXT_W        = ARRAY_W + 1;
    localparam int CLK_BIT      = ARRAY_W;
    localparam int SIG_W        = 64;

    // cells that own the longer sum terms
    localparam logic [NUM_CELLS-1:0] WIDE_CELLS = 10'h030;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_POLARITY  = 12'h000;
    localparam logic [ADDR_W-1:0] REG_MODE      = 12'h004;
    localparam logic [ADDR_W-1:0] REG_OE_SEL    = 12'h008;
    localparam logic [ADDR_W-1:0] REG_PRELOAD   = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_CELL_Q    = 12'h010;
    localparam logic [ADDR_W-1:0] REG_PIN_IN    = 12'h014;
    localparam logic [ADDR_W-1:0] REG_INPUT_IN  = 12'h018;
    localparam logic [ADDR_W-1:0] REG_SIG_LO    = 12'h01c;
    localparam logic [ADDR_W-1:0] REG_SIG_HI    = 12'h020;
    localparam logic [ADDR_W-1:0] REG_TERM_BASE = 12'h400;
    localparam int                TERM_SHIFT    = 3;
    localparam int                TERM_HALF_BIT = 2;

    // reset values
    localparam logic [NUM_CELLS-1:0]   POLARITY_RST = 10'h3ff;
    localparam logic [NUM_CELLS-1:0]   MODE_RST     = 10'h000;
    localparam logic [2*NUM_CELLS-1:0] OE_SEL_RST   = 20'h00000;
    localparam logic [ARRAY_W-1:0]     MASK_RST     = 18'h3ffff;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OE_BY_TERM, OE_ALWAYS_ON, OE_ALWAYS_OFF} omc_oe_sel_e;

    typedef struct packed {
        logic        polarity_true;
        logic        comb_mode;
        omc_oe_sel_e oe_sel;
    } omc_cell_cfg_s;

    typedef struct packed {
        logic [ARRAY_W-1:0] true_mask;
        logic [ARRAY_W-1:0] comp_mask;
    } omc_term_s;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } omc_axi_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } omc_axi_rsp_s;

endpackage : omc_pkg
